// *** src/pin_route_top.sv ***
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module pin_route_top
	import pin_route_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// avalon-mm slave
	input wire logic [9:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// status sources
	input wire rx_status_t [RX_PORTS-1:0] i_rx,
	input wire tx_status_t [TX_PORTS-1:0] i_tx,
	input wire logic i_frame_sync_pulse,
	// pin drive
	output logic o_pin_out,
	output logic o_pin_oe
);
	logic ack_reg;
	logic ack_next;
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [15:0] mask_reg;
	logic [15:0] mask_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic mux_raw;

	// request decode
	wire req = i_avs_read | i_avs_write;
	wire [7:0] idx = i_avs_address[9:2];
	wire hit_ctrl = (idx == CTRL_IDX);
	wire hit_mask = (idx == MASK_IDX);
	wire hit_stat = (idx == STAT_IDX);
	wire wr_fire = i_avs_write & ack_reg;
	wire wr_ctrl = wr_fire & hit_ctrl & i_avs_byteenable[0];
	wire wr_mask0 = wr_fire & hit_mask & i_avs_byteenable[0];
	wire wr_mask1 = wr_fire & hit_mask & i_avs_byteenable[1];
	wire rd_load = i_avs_read & ~ack_reg;

	// one wait cycle: answer lands on the second edge of a request
	assign ack_next = req & ~ack_reg;
	assign o_avs_waitrequest = req & ~ack_reg;

	// writes commit only at the edge where waitrequest is low
	assign ctrl_next = wr_ctrl ? i_avs_writedata[7:0] : ctrl_reg;
	assign mask_next = {wr_mask1 ? i_avs_writedata[15:8] : mask_reg[15:8],
		wr_mask0 ? i_avs_writedata[7:0] : mask_reg[7:0]};

	// read mux; unmapped words read as zero
	assign rdata_next = hit_ctrl ? {24'h0, ctrl_reg} :
		hit_mask ? {16'h0, mask_reg} :
		hit_stat ? {29'h0, mux_raw, o_pin_out, o_pin_oe} : 32'h0;

	// bus handshake state
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
		end
	end

	// control registers
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			ctrl_reg <= CTRL_RST;
			mask_reg <= MASK_RST;
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
		end
	end

	// read data captured in the wait cycle, stable when answered
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			rdata_reg <= 32'h0;
		end else if (rd_load) begin
			rdata_reg <= rdata_next;
		end
	end

	assign o_avs_readdata = rdata_reg;

	// source selection and driver
	pin_source_mux u_mux (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_ctrl(ctrl_reg),
		.i_mask(mask_reg),
		.i_rx(i_rx),
		.i_tx(i_tx),
		.i_frame_sync_pulse(i_frame_sync_pulse),
		.o_raw(mux_raw),
		.o_pin_out(o_pin_out),
		.o_pin_oe(o_pin_oe)
	);

	// field views for the checks below
	wire [2:0] a_sel = ctrl_reg[SEL_MSB:SEL_LSB];
	wire [2:0] a_src = ctrl_reg[SRC_MSB:SRC_LSB];
	wire a_en = ctrl_reg[EN_BIT];
	wire a_rx = (a_src[2] == 1'b0);
	wire [1:0] a_port = a_src[1:0];
	wire a_tx = (a_src == SRC_TX0) || (a_src == SRC_TX1);
	wire a_tp = a_src[0];
	wire [3:0] a_rxen = mask_reg[RXEN_LSB +: 4];
	wire [3:0] a_txm = a_tp ? mask_reg[TX1M_LSB +: 4] :
		mask_reg[TX0M_LSB +: 4];
	wire [3:0] a_lock = {i_rx[3].lock, i_rx[2].lock,
		i_rx[1].lock, i_rx[0].lock};
	wire [3:0] a_pass = {i_rx[3].pass, i_rx[2].pass,
		i_rx[1].pass, i_rx[0].pass};
	wire a_wr_done = i_avs_write && !o_avs_waitrequest;
	wire a_rd_done = i_avs_read && !o_avs_waitrequest;

	// a bus write followed by the drive it causes two edges later
	sequence s_ctrl_write;
		i_avs_write && hit_ctrl && i_avs_byteenable[0] && !ack_reg;
	endsequence

	sequence s_write_done;
		##1 (!o_avs_waitrequest && i_avs_write) ##1 1'b1;
	endsequence

	AST_SRC_RX_REMOTE: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_rx && a_en && a_sel < SEL_LOCK) |=>
		(o_pin_out == $past(i_rx[a_port].remote[a_sel[1:0]]))
	) else $error("rx remote pin not forwarded");

	AST_RX_REMOTE_RAW: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_rx && a_sel[2] == 1'b0 && $stable(ctrl_reg)) |=>
		(mux_raw == $past(i_rx[a_port].remote[a_sel[1:0]]))
	) else $error("remote pin select wrong");

	AST_RX_LOCK: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_rx && a_sel == SEL_LOCK) |=>
		(mux_raw == $past(i_rx[a_port].lock))
	) else $error("rx lock not shown");

	AST_RX_PASS: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_rx && a_sel == SEL_PASS) |=>
		(mux_raw == $past(i_rx[a_port].pass))
	) else $error("rx pass not shown");

	AST_RX_VALIDS: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_rx && a_sel[2:1] == 2'h3) |=>
		(mux_raw == (($past(a_sel) == SEL_FV) ?
			$past(i_rx[a_port].frame_valid) :
			$past(i_rx[a_port].line_valid)))
	) else $error("rx frame or line valid not shown");

	AST_DEV_OR_LOCK: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_src == SRC_STATUS && a_sel == DSEL_OR_LOCK) |=>
		(mux_raw == |($past(a_lock) & $past(a_rxen)))
	) else $error("or of enabled lock wrong");

	AST_DEV_AND_PASS: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_src == SRC_STATUS && a_sel == DSEL_AND_PASS) |=>
		(mux_raw == &($past(a_pass) | ~$past(a_rxen)))
	) else $error("and of enabled pass wrong");

	AST_DEV_FSYNC: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_src == SRC_STATUS && a_sel == DSEL_FSYNC) |=>
		(mux_raw == $past(i_frame_sync_pulse))
	) else $error("frame sync not shown");

	AST_DEV_RSVD: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_src == SRC_STATUS && a_sel > DSEL_FSYNC) |=> !mux_raw
	) else $error("reserved status select not low");

	AST_LOCAL_VALUE: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_src == SRC_STATUS && a_sel == DSEL_VAL && a_en)[*2] |->
		(o_pin_out == $past(ctrl_reg[VAL_BIT]))
	) else $error("local value not driven");

	AST_TX_AND_OR: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_tx && a_sel[2:1] == 2'h0) |=>
		(mux_raw == ($past(a_sel[0]) ?
			|($past(a_pass) & $past(a_txm)) :
			&($past(a_pass) | ~$past(a_txm))))
	) else $error("tx pass combine wrong");

	AST_TX_VALIDS: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_tx && a_sel[2:1] == 2'h1) |=>
		(mux_raw == ($past(a_sel[0]) ?
			$past(i_tx[a_tp].line_valid) :
			$past(i_tx[a_tp].frame_valid)))
	) else $error("tx frame or line valid wrong");

	AST_TX_SYNC_IRQ: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_tx && a_sel[2:1] == 2'h2) |=>
		(mux_raw == ($past(a_sel[0]) ?
			$past(i_tx[a_tp].irq) :
			$past(i_tx[a_tp].synced)))
	) else $error("tx sync or interrupt wrong");

	AST_TX_RSVD: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_tx && a_sel == 3'h7) |=> !mux_raw
	) else $error("reserved tx select not low");

	AST_RSVD_SRC: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_src == SRC_RSVD) |=> !mux_raw
	) else $error("reserved source not low");

	AST_DRIVER_OFF: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		!a_en |=> (!o_pin_oe && !o_pin_out)
	) else $error("pin driven while disabled");

	AST_WRITE_ENABLES: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(s_ctrl_write ##0 (i_avs_writedata[EN_BIT] == 1'b1))
		##1 (!o_avs_waitrequest) |=> ##1 o_pin_oe
	) else $error("enable write did not reach driver");

	AST_WRITE_LANDS: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		s_ctrl_write |-> s_write_done ##0
		(ctrl_reg == $past(i_avs_writedata[7:0]))
	) else $error("control write not stored");

	AST_RESET_ZERO: assert property (
		@(posedge i_clk)
		$rose(i_nrst) |-> (ctrl_reg == 8'h00 && !o_pin_oe)
	) else $error("control not zero after reset");

	AST_WAIT_ONE: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(req && !ack_reg) |-> o_avs_waitrequest ##1
		(!o_avs_waitrequest || !req)
	) else $error("waitrequest held too long");

	// bus answers, read-back paths and driver invariants
	AST_ONE_ACK: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		ack_reg |=> !ack_reg
	) else $error("acknowledge held two cycles");

	AST_READ_STANDS: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		a_rd_done |=> $stable(o_avs_readdata)
	) else $error("read data moved after answer");

	AST_READ_CTRL: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_rd_done && hit_ctrl) |->
		(o_avs_readdata == {24'h0, ctrl_reg})
	) else $error("control read-back wrong");

	AST_READ_MASK: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_rd_done && hit_mask) |->
		(o_avs_readdata == {16'h0, mask_reg})
	) else $error("mask read-back wrong");

	AST_READ_STAT: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_rd_done && hit_stat) |-> (o_avs_readdata ==
		{29'h0, $past(mux_raw), $past(o_pin_out), $past(o_pin_oe)})
	) else $error("status read-back wrong");

	AST_READ_UNMAPPED: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_rd_done && !hit_ctrl && !hit_mask && !hit_stat) |->
		(o_avs_readdata == 32'h0)
	) else $error("unmapped read not zero");

	AST_WRITE_IGNORED: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_wr_done && !hit_ctrl && !hit_mask) |=>
		($stable(ctrl_reg) && $stable(mask_reg))
	) else $error("unmapped write changed a register");

	AST_LANE_OFF: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_wr_done && hit_ctrl && !i_avs_byteenable[0]) |=>
		$stable(ctrl_reg)
	) else $error("control written with lane off");

	AST_MASK_LOW: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_wr_done && hit_mask && i_avs_byteenable[0]) |=>
		(mask_reg[7:0] == $past(i_avs_writedata[7:0]))
	) else $error("mask low byte not stored");

	AST_MASK_HIGH: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(a_wr_done && hit_mask && i_avs_byteenable[1]) |=>
		(mask_reg[15:8] == $past(i_avs_writedata[15:8]))
	) else $error("mask high byte not stored");

	AST_OE_ON: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		a_en |=> o_pin_oe
	) else $error("driver not enabled");

	AST_PIN_GATED: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		o_pin_out == (mux_raw && o_pin_oe)
	) else $error("pin level not gated by enable");

	AST_RESET_MASK: assert property (
		@(posedge i_clk)
		$rose(i_nrst) |-> (mask_reg == MASK_RST && !o_pin_out)
	) else $error("mask not zero after reset");
endmodule : pin_route_top

// *** src/pin_route_pkg.sv ***
package pin_route_pkg;
	localparam int RX_PORTS = 4;
	localparam int TX_PORTS = 2;
	// register indices; byte address is four times the index
	localparam logic [7:0] CTRL_IDX = 8'h12;
	localparam logic [7:0] MASK_IDX = 8'h20;
	localparam logic [7:0] STAT_IDX = 8'h21;
	// control register field positions
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 5;
	localparam int SRC_MSB = 4;
	localparam int SRC_LSB = 2;
	localparam int VAL_BIT = 1;
	localparam int EN_BIT = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// port mask register: rx enable, tx0 rx choice, tx1 rx choice
	localparam int RXEN_LSB = 0;
	localparam int TX0M_LSB = 4;
	localparam int TX1M_LSB = 8;
	localparam logic [15:0] MASK_RST = 16'h0000;
	// source codes
	localparam logic [2:0] SRC_STATUS = 3'h4;
	localparam logic [2:0] SRC_RSVD = 3'h5;
	localparam logic [2:0] SRC_TX0 = 3'h6;
	localparam logic [2:0] SRC_TX1 = 3'h7;
	// select codes used in several places
	localparam logic [2:0] SEL_LOCK = 3'h4;
	localparam logic [2:0] SEL_PASS = 3'h5;
	localparam logic [2:0] SEL_FV = 3'h6;
	localparam logic [2:0] SEL_LV = 3'h7;
	localparam logic [2:0] DSEL_VAL = 3'h0;
	localparam logic [2:0] DSEL_OR_LOCK = 3'h1;
	localparam logic [2:0] DSEL_AND_PASS = 3'h2;
	localparam logic [2:0] DSEL_FSYNC = 3'h4;
	localparam logic [2:0] TSEL_AND = 3'h0;
	localparam logic [2:0] TSEL_OR = 3'h1;
	localparam logic [2:0] TSEL_FV = 3'h2;
	localparam logic [2:0] TSEL_LV = 3'h3;
	localparam logic [2:0] TSEL_SYNC = 3'h4;
	localparam logic [2:0] TSEL_IRQ = 3'h5;
	// per receive port status bundle
	typedef struct packed {
		logic [3:0] remote;
		logic lock;
		logic pass;
		logic frame_valid;
		logic line_valid;
	} rx_status_t;
	// per transmit port status bundle
	typedef struct packed {
		logic frame_valid;
		logic line_valid;
		logic synced;
		logic irq;
	} tx_status_t;
endpackage : pin_route_pkg

// *** src/pin_source_mux.sv ***
`timescale 1ns/1ps
module pin_source_mux
	import pin_route_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// control fields
	input wire logic [7:0] i_ctrl,
	input wire logic [15:0] i_mask,
	// status sources
	input wire rx_status_t [RX_PORTS-1:0] i_rx,
	input wire tx_status_t [TX_PORTS-1:0] i_tx,
	input wire logic i_frame_sync_pulse,
	// pin drive
	output logic o_raw,
	output logic o_pin_out,
	output logic o_pin_oe
);
	wire [2:0] sel = i_ctrl[SEL_MSB:SEL_LSB];
	wire [2:0] src = i_ctrl[SRC_MSB:SRC_LSB];
	wire [3:0] rx_en = i_mask[RXEN_LSB +: RX_PORTS];
	wire [7:0] rx_vec [RX_PORTS];
	wire [7:0] tx_vec [TX_PORTS];
	wire [3:0] lock_v;
	wire [3:0] pass_v;
	wire [7:0] dev_vec;
	wire or_lock;
	wire and_pass;
	wire raw;
	logic raw_reg;
	logic out_reg;
	logic oe_reg;

	// per rx port candidates, indexed by select code
	genvar p;
	generate
		for (p = 0; p < RX_PORTS; p++) begin : g_rx
			assign rx_vec[p] = {i_rx[p].line_valid, i_rx[p].frame_valid,
				i_rx[p].pass, i_rx[p].lock, i_rx[p].remote};
			assign lock_v[p] = i_rx[p].lock;
			assign pass_v[p] = i_rx[p].pass;
		end
	endgenerate

	// device-wide status; with no port enabled the AND reads high
	assign or_lock = |(lock_v & rx_en);
	assign and_pass = &(pass_v | ~rx_en);
	assign dev_vec = {3'h0, i_frame_sync_pulse, and_pass, and_pass,
		or_lock, i_ctrl[VAL_BIT]};

	// per tx port candidates over the rx ports chosen for that port
	genvar t;
	generate
		for (t = 0; t < TX_PORTS; t++) begin : g_tx
			wire [3:0] m = i_mask[TX0M_LSB + 4*t +: 4];
			assign tx_vec[t] = {2'h0, i_tx[t].irq, i_tx[t].synced,
				i_tx[t].line_valid, i_tx[t].frame_valid,
				|(pass_v & m), &(pass_v | ~m)};
		end
	endgenerate

	// source choice; the reserved source drives low
	assign raw = (src[2] == 1'b0) ? rx_vec[src[1:0]][sel] :
		(src == SRC_STATUS) ? dev_vec[sel] :
		(src == SRC_TX0) ? tx_vec[0][sel] :
		(src == SRC_TX1) ? tx_vec[1][sel] : 1'b0;

	// registered drive; level parked low while the driver is off
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			raw_reg <= 1'b0;
			out_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			raw_reg <= raw;
			out_reg <= raw & i_ctrl[EN_BIT];
			oe_reg <= i_ctrl[EN_BIT];
		end
	end

	assign o_raw = raw_reg;
	assign o_pin_out = out_reg;
	assign o_pin_oe = oe_reg;
endmodule : pin_source_mux

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
	import pin_route_pkg::*;
	localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'h0};
	localparam logic [9:0] MASK_ADDR = {MASK_IDX, 2'h0};
	localparam logic [9:0] STAT_ADDR = {STAT_IDX, 2'h0};
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic [9:0] address = 10'h000;
	logic rd = 1'h0;
	logic wr = 1'h0;
	logic [3:0] be = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic waitreq;
	rx_status_t [RX_PORTS-1:0] rx = 32'h0;
	tx_status_t [TX_PORTS-1:0] tx = 8'h00;
	logic fsync = 1'h0;
	logic pin_out;
	logic pin_oe;
	int bad_count = 0;
	int num_checks = 0;

	// 20 MHz clock
	always #25 clk = ~clk;

	pin_route_top u_pin_route_top (
		.i_clk(clk), .i_nrst(nrst), .i_avs_address(address),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be),
		.i_avs_writedata(wdata), .o_avs_readdata(rdata),
		.o_avs_waitrequest(waitreq), .i_rx(rx), .i_tx(tx),
		.i_frame_sync_pulse(fsync), .o_pin_out(pin_out), .o_pin_oe(pin_oe)
	);

	task check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task chk1(input string name, input logic seen, input logic exp);
		check(name, {31'h0, seen}, {31'h0, exp});
	endtask : chk1

	// one avalon access; request held until waitrequest is seen low
	task bus(input logic is_wr, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] b, output logic [31:0] q);
		int n;
		@(posedge clk);
		address <= a;
		wr <= is_wr;
		rd <= ~is_wr;
		wdata <= d;
		be <= b;
		n = 0;
		// no local limit: only the watchdog may end a stalled access
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'h0);
		q = rdata;
		check("wait_cycles", n, 32'h2);
		wr <= 1'h0;
		rd <= 1'h0;
	endtask : bus

	task wreg(input logic [9:0] a, input logic [31:0] d, input logic [3:0] b);
		logic [31:0] q;
		bus(1'h1, a, d, b, q);
	endtask : wreg

	task rreg(input logic [9:0] a, input logic [31:0] exp, input string name);
		logic [31:0] q;
		bus(1'h0, a, 32'h0, 4'hf, q);
		check(name, q, exp);
	endtask : rreg

	// pin is registered one cycle behind its inputs; three edges is ample
	task settle;
		repeat (3) @(posedge clk);
	endtask : settle

	task set_ctrl(input logic [2:0] sel, input logic [2:0] src,
		input logic val, input logic en);
		wreg(CTRL_ADDR, {24'h0, sel, src, val, en}, 4'h1);
		settle();
	endtask : set_ctrl

	task test_regs;
		chk1("oe_rst", pin_oe, 1'h0);
		rreg(CTRL_ADDR, 32'h0, "ctrl_rst");
		rreg(MASK_ADDR, 32'h0, "mask_rst");
		wreg(CTRL_ADDR, 32'ha5, 4'h0);
		rreg(CTRL_ADDR, 32'h0, "ctrl_no_lane");
		wreg(CTRL_ADDR, 32'ha5, 4'h1);
		rreg(CTRL_ADDR, 32'ha5, "ctrl_rw");
		wreg(10'h3fc, 32'hffff_ffff, 4'hf);
		rreg(10'h3fc, 32'h0, "unmapped");
	endtask : test_regs

	// target bit low and rest of its port high, then the inverse, per port/select; other ports get the complement
	task test_rx;
		logic [7:0] pat;
		for (int p = 0; p < 4; p++) begin
			for (int s = 0; s < 8; s++) begin
				for (int v = 0; v < 2; v++) begin
					pat = 8'h00;
					pat[s < 4 ? 4 + s : 7 - s] = 1'h1;
					if (v == 0) pat = ~pat;
					for (int q = 0; q < 4; q++) rx[q] <= (q == p) ? pat : ~pat;
					set_ctrl(3'(s), 3'(p), 1'h0, 1'h1);
					chk1("rx_pin", pin_out, v[0]);
				end
			end
		end
	endtask : test_rx

	// rx ports 0 and 2 enabled; tx0 takes ports 0,1 and tx1 ports 2,3
	task test_status;
		wreg(MASK_ADDR, 32'hc35, 4'h1);
		rreg(MASK_ADDR, 32'h35, "mask_lane0");
		wreg(MASK_ADDR, 32'hc35, 4'h3);
		rreg(MASK_ADDR, 32'hc35, "mask");
		set_ctrl(DSEL_VAL, SRC_STATUS, 1'h1, 1'h1);
		chk1("local_hi", pin_out, 1'h1);
		set_ctrl(DSEL_VAL, SRC_STATUS, 1'h0, 1'h1);
		chk1("local_lo", pin_out, 1'h0);
		rx <= 32'h0000_0800;
		set_ctrl(DSEL_OR_LOCK, SRC_STATUS, 1'h1, 1'h1);
		chk1("or_lock_off", pin_out, 1'h0);
		rx <= 32'h0008_0800;
		settle();
		chk1("or_lock_on", pin_out, 1'h1);
		rx <= 32'h0004_0004;
		set_ctrl(DSEL_AND_PASS, SRC_STATUS, 1'h0, 1'h1);
		chk1("and_pass_hi", pin_out, 1'h1);
		set_ctrl(3'h3, SRC_STATUS, 1'h0, 1'h1);
		chk1("and_pass_dup", pin_out, 1'h1);
		rx <= 32'h0000_0004;
		settle();
		chk1("and_pass_lo", pin_out, 1'h0);
		set_ctrl(DSEL_FSYNC, SRC_STATUS, 1'h0, 1'h1);
		fsync <= 1'h1;
		settle();
		chk1("fsync_hi", pin_out, 1'h1);
		fsync <= 1'h0;
		settle();
		chk1("fsync_lo", pin_out, 1'h0);
		rx <= 32'hffff_ffff;
		fsync <= 1'h1;
		for (int s = 5; s < 8; s++) begin
			set_ctrl(3'(s), SRC_STATUS, 1'h1, 1'h1);
			chk1("status_rsvd", pin_out, 1'h0);
		end
		set_ctrl(DSEL_VAL, SRC_RSVD, 1'h1, 1'h1);
		chk1("src_rsvd", pin_out, 1'h0);
	endtask : test_status

	task test_tx;
		logic [3:0] ps;
		logic [3:0] pat;
		logic [3:0] ex;
		for (int k = 0; k < 2; k++) begin
			ps = k ? 4'h4 : 4'hd;
			for (int q = 0; q < 4; q++) rx[q] <= {5'h00, ps[q], 2'h0};
			ex = {|ps[3:2], &ps[3:2], |ps[1:0], &ps[1:0]};
			for (int t = 0; t < 4; t++) begin
				set_ctrl(3'(t % 2), t < 2 ? SRC_TX0 : SRC_TX1, 1'h0, 1'h1);
				chk1("tx_pass", pin_out, ex[t]);
			end
		end
		for (int t = 0; t < 2; t++) begin
			for (int s = 2; s < 6; s++) begin
				for (int v = 0; v < 2; v++) begin
					pat = 4'h0;
					pat[5 - s] = 1'h1;
					if (v == 0) pat = ~pat;
					tx <= t ? {pat, ~pat} : {~pat, pat};
					set_ctrl(3'(s), t ? SRC_TX1 : SRC_TX0, 1'h0, 1'h1);
					chk1("tx_field", pin_out, v[0]);
				end
			end
		end
		tx <= 8'hff;
		for (int s = 6; s < 8; s++) begin
			set_ctrl(3'(s), SRC_TX1, 1'h1, 1'h1);
			chk1("tx_rsvd", pin_out, 1'h0);
		end
	endtask : test_tx

	task test_enable;
		set_ctrl(TSEL_FV, SRC_TX0, 1'h1, 1'h0);
		chk1("off_level", pin_out, 1'h0);
		chk1("off_oe", pin_oe, 1'h0);
		rreg(STAT_ADDR, 32'h4, "stat_off");
		set_ctrl(TSEL_FV, SRC_TX0, 1'h1, 1'h1);
		chk1("on_oe", pin_oe, 1'h1);
		rreg(STAT_ADDR, 32'h7, "stat_on");
		// a second reset in mid-run must clear every field again
		nrst <= 1'h0;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		settle();
		chk1("rst2_oe", pin_oe, 1'h0);
		rreg(CTRL_ADDR, 32'h0, "ctrl_rst2");
		rreg(MASK_ADDR, 32'h0, "mask_rst2");
	endtask : test_enable

	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'h1;
		test_regs();
		test_rx();
		test_status();
		test_tx();
		test_enable();
		print_verdict();
	end

	// watchdog: the run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		print_verdict();
	end
endmodule : tb
